// [lcdc_consts.svh]
// Register indices, field positions, reset values and timing figures
`ifndef LCDC_CONSTS_SVH
`define LCDC_CONSTS_SVH

`define LCDC_IDX_CTRL1       4'h0
`define LCDC_IDX_CTRL2       4'h1
`define LCDC_IDX_PTR         4'h2
`define LCDC_IDX_START       4'h3
`define LCDC_IDX_DATA        4'h4
`define LCDC_IDX_BLINK_PAT   4'h6
`define LCDC_IDX_BLINK_FIRST 4'h8
`define LCDC_IDX_BLINK_LAST  4'h9
`define LCDC_IDX_CONTRAST    4'ha

`define LCDC_C1_DUTY_LO      0
`define LCDC_C1_DUTY_HI      1
`define LCDC_C1_GRAPHIC      2
`define LCDC_C1_STEP_UP      3
`define LCDC_C1_STANDBY      4

`define LCDC_C2_DISPLAY_ON_ON      0
`define LCDC_C2_OPAMP        1
`define LCDC_C2_BLINK        2
`define LCDC_C2_AXIS         3
`define LCDC_C2_RMW          4

`define LCDC_RST_BYTE        8'h00
`define LCDC_RST_LAST_LINE   5'h1f
`define LCDC_Y_MAX           5'h1f
`define LCDC_X_MAX_FULL      3'h7
`define LCDC_X_MAX_56        3'h6
`define LCDC_X_MAX_40        3'h4
`define LCDC_CHAR_BITS       5

`define LCDC_CLK_HZ          50000000
`define LCDC_FRAME_HZ        80
`define LCDC_BLINK_PERIOD_MS 1600
`define LCDC_MS_PER_S        1000
`define LCDC_MAX_LINES       32

`endif

// [lcdc_pkg.sv]
// Types shared by the display controller files
package lcdc_pkg;

	typedef enum logic [1:0] {
		LCDC_DUTY_32,
		LCDC_DUTY_16,
		LCDC_DUTY_8
	} lcdc_duty_t;

	typedef struct packed {
		logic       rs;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} lcdc_bus_t;

	typedef struct packed {
		logic [2:0] x;
		logic [4:0] y;
	} lcdc_ptr_t;

endpackage

// [lcdc_dpram.sv]
// Display memory: CPU byte port and independent refresh row port
`timescale 1ns/100ps
module lcdc_dpram #(
	parameter int LINES = 32,
	parameter int BYTES = 8
) (
	input  wire logic                     i_clk,
	input  wire logic                     i_rst_n,
	input  wire logic                     i_cpu_we,
	input  wire logic                     i_cpu_re,
	input  wire logic [$clog2(BYTES)-1:0] i_cpu_x,
	input  wire logic [$clog2(LINES)-1:0] i_cpu_y,
	input  wire logic [7:0]               i_cpu_wdata,
	output logic      [7:0]               o_cpu_rdata,
	input  wire logic [$clog2(LINES)-1:0] i_display_on_y,
	output logic      [8*BYTES-1:0]       o_display_on_row
);

	initial begin
		if (LINES < 2 || BYTES < 2)
			$error("lcdc_dpram: geometry too small");
	end

	logic [7:0] mem [0:LINES-1][0:BYTES-1];

	always_ff @(posedge i_clk) begin
		if (i_cpu_we)
			mem[i_cpu_y][i_cpu_x] <= i_cpu_wdata;
	end

	// Reads other than the data port answer zero
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			o_cpu_rdata <= 8'h00;
		else if (i_cpu_re)
			o_cpu_rdata <= mem[i_cpu_y][i_cpu_x];
		else
			o_cpu_rdata <= 8'h00;
	end

	// Leftmost byte lands in the top bits of the row
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_display_on_row <= '0;
		end else begin
			for (int b = 0; b < BYTES; b++)
				o_display_on_row[8*(BYTES-1-b) +: 8] <= mem[i_display_on_y][b];
		end
	end

endmodule

// [lcdc_top.sv]
// Dot-matrix display controller: registers, address stepping, scan, blink, power
//
// Notes on behaviour
// - CPU memory access independent of refresh reads
// - Normal mode steps address after read or write
// - RMW mode steps only after a write
// - First panel line shows start line, wrapping
// - Blink period about 1.6 s at 80 Hz
// - Blink lines bounded; 5 or 8-bit groups
// - Pattern bit one marks group as blinking
// - Blinking only while blink enable is set
// - Blink lines match absolute memory line addresses
// - Standby stops power, forces SEG and COM outputs to ground
// - Standby clears display on and op-amp bits
// - Registers stay accessible during module standby
// - Chip standby switches pump off within two subclocks
// - Step-up bit enables pump, clocked by subclock
// - Op-amp bit runs the voltage followers
// - Both bits clear halts pump and amplifiers
// - Axis bit picks X or Y stepping
// - Stepped axis wraps, other axis increments
// - Index then data access; only data readable
//
// The register addresses and the strobed register port were chosen for this implementation.
`include "lcdc_consts.svh"
`timescale 1ns/100ps
module lcdc_top
	import lcdc_pkg::*;
#(
	parameter int CLK_HZ      = `LCDC_CLK_HZ,
	parameter int LINE_CYCLES = CLK_HZ / (`LCDC_FRAME_HZ * `LCDC_MAX_LINES)
) (
	input  wire logic        I_CLK,
	input  wire logic        I_RST_N,
	input  wire logic        I_RS,
	input  wire logic        I_WR,
	input  wire logic        I_RD,
	input  wire logic [7:0]  I_WDATA,
	output logic      [7:0]  O_RDATA,
	input  wire logic        I_CHIP_STANDBY,
	input  wire logic        I_SUBCLK,
	output logic      [31:0] O_COM,
	output logic      [63:0] O_SEG,
	output logic             O_PUMP_EN,
	output logic             O_PUMP_CLK,
	output logic             O_OPAMP_EN,
	output logic      [3:0]  O_CONTRAST
);

	localparam int BLINK_HALF_FRAMES =
		`LCDC_BLINK_PERIOD_MS * `LCDC_FRAME_HZ / (2 * `LCDC_MS_PER_S);

	initial begin
		if (LINE_CYCLES < 1 || LINE_CYCLES > 262143)
			$error("lcdc_top: LINE_CYCLES out of range");
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset release and bus packing

	logic      rst_meta_reg;
	logic      rst_n;
	lcdc_bus_t bus;

	always_ff @(posedge I_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	assign bus = '{rs: I_RS, wr: I_WR, rd: I_RD, wdata: I_WDATA};

	////////////////////////////////////////////////////////////////////////////
	// Helper functions

	function automatic lcdc_duty_t duty_of(input logic hi, input logic lo);
		if (hi)
			return LCDC_DUTY_8;
		else if (lo)
			return LCDC_DUTY_16;
		else
			return LCDC_DUTY_32;
	endfunction

	function automatic logic [4:0] line_mask(input lcdc_duty_t d);
		unique case (d)
			LCDC_DUTY_8:  return 5'h07;
			LCDC_DUTY_16: return 5'h0f;
			LCDC_DUTY_32: return 5'h1f;
		endcase
	endfunction

	function automatic logic [2:0] x_limit(input logic gfx, input lcdc_duty_t d);
		if (!gfx)
			return `LCDC_X_MAX_FULL;
		unique case (d)
			LCDC_DUTY_8:  return `LCDC_X_MAX_FULL;
			LCDC_DUTY_16: return `LCDC_X_MAX_56;
			LCDC_DUTY_32: return `LCDC_X_MAX_40;
		endcase
	endfunction

	function automatic lcdc_ptr_t ptr_step(input lcdc_ptr_t p, input logic axis_x,
	                                       input logic [2:0] xmax);
		lcdc_ptr_t n;
		n = p;
		if (axis_x) begin
			if (p.x >= xmax) begin
				n.x = 3'h0;
				n.y = p.y + 5'h01;
			end else begin
				n.x = p.x + 3'h1;
			end
		end else begin
			if (p.y == `LCDC_Y_MAX) begin
				n.y = 5'h00;
				n.x = (p.x >= xmax) ? 3'h0 : p.x + 3'h1;
			end else begin
				n.y = p.y + 5'h01;
			end
		end
		return n;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Register file

	logic [3:0] index_reg;
	logic [7:0] ctrl1_reg;
	logic [7:0] ctrl2_reg;
	logic [4:0] start_reg;
	logic [7:0] blink_pat_reg;
	logic [4:0] blink_first_reg;
	logic [4:0] blink_last_reg;
	logic [3:0] contrast_reg;
	lcdc_ptr_t  ptr_reg;
	logic       data_wr;
	logic       data_rd;
	logic       reg_wr;
	logic       standby;
	lcdc_duty_t duty;
	logic       gfx;

	assign reg_wr  = bus.wr && bus.rs;
	assign data_wr = reg_wr && index_reg == `LCDC_IDX_DATA;
	assign data_rd = bus.rd && bus.rs && index_reg == `LCDC_IDX_DATA;
	assign standby = ctrl1_reg[`LCDC_C1_STANDBY];
	assign duty    = duty_of(ctrl1_reg[`LCDC_C1_DUTY_HI], ctrl1_reg[`LCDC_C1_DUTY_LO]);
	assign gfx     = ctrl1_reg[`LCDC_C1_GRAPHIC];

	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n)
			index_reg <= 4'h0;
		else if (bus.wr && !bus.rs)
			index_reg <= bus.wdata[3:0];
	end

	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl1_reg       <= `LCDC_RST_BYTE;
			start_reg       <= 5'h00;
			blink_pat_reg   <= `LCDC_RST_BYTE;
			blink_first_reg <= 5'h00;
			blink_last_reg  <= `LCDC_RST_LAST_LINE;
			contrast_reg    <= 4'h0;
		end else if (reg_wr) begin
			unique case (index_reg)
				`LCDC_IDX_CTRL1:       ctrl1_reg       <= {3'h0, bus.wdata[4:0]};
				`LCDC_IDX_START:       start_reg       <= bus.wdata[4:0];
				`LCDC_IDX_BLINK_PAT:   blink_pat_reg   <= bus.wdata;
				`LCDC_IDX_BLINK_FIRST: blink_first_reg <= bus.wdata[4:0];
				`LCDC_IDX_BLINK_LAST:  blink_last_reg  <= bus.wdata[4:0];
				`LCDC_IDX_CONTRAST:    contrast_reg    <= bus.wdata[3:0];
				default: ;
			endcase
		end
	end

	// standby drops display on and op-amp, keeps the rest
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			ctrl2_reg <= `LCDC_RST_BYTE;
		end else begin
			if (reg_wr && index_reg == `LCDC_IDX_CTRL2)
				ctrl2_reg <= {3'h0, bus.wdata[4:0]};
			if (standby) begin
				ctrl2_reg[`LCDC_C2_DISPLAY_ON_ON] <= 1'b0;
				ctrl2_reg[`LCDC_C2_OPAMP]   <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Memory pointer and data port

	lcdc_ptr_t ptr_next;
	logic      rmw;

	assign rmw = ctrl2_reg[`LCDC_C2_RMW];

	// stepped axis wraps into the other
	assign ptr_next = ptr_step(ptr_reg, ctrl2_reg[`LCDC_C2_AXIS], x_limit(gfx, duty));

	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n)
			ptr_reg <= '0;
		else if (reg_wr && index_reg == `LCDC_IDX_PTR)
			ptr_reg <= bus.wdata;
		// normal mode steps on read or write
		// RMW read leaves address in place
		// RMW write uses the common step
		else if (data_wr || (data_rd && !rmw))
			ptr_reg <= ptr_next;
	end

	logic [4:0]  display_on_y;
	logic [63:0] display_on_row;

	// separate refresh port never waits on the CPU
	lcdc_dpram #(
		.LINES(`LCDC_MAX_LINES),
		.BYTES(8)
	) u_mem (
		.i_clk      (I_CLK),
		.i_rst_n    (rst_n),
		.i_cpu_we   (data_wr),
		.i_cpu_re   (data_rd),
		.i_cpu_x    (ptr_reg.x),
		.i_cpu_y    (ptr_reg.y),
		.i_cpu_wdata(bus.wdata),
		.o_cpu_rdata(O_RDATA),
		.i_display_on_y   (display_on_y),
		.o_display_on_row (display_on_row)
	);

	////////////////////////////////////////////////////////////////////////////
	// Line and frame timing

	logic [19:0] line_cnt_reg;
	logic [19:0] line_len;
	logic [4:0]  line_reg;
	logic        line_tick;
	logic        frame_tick;

	// Lower duty stretches the line so the frame rate holds
	always_comb begin
		unique case (duty)
			LCDC_DUTY_8:  line_len = 20'(LINE_CYCLES * 4);
			LCDC_DUTY_16: line_len = 20'(LINE_CYCLES * 2);
			LCDC_DUTY_32: line_len = 20'(LINE_CYCLES);
		endcase
	end

	assign line_tick  = line_cnt_reg >= line_len - 20'h00001;
	assign frame_tick = line_tick && line_reg == line_mask(duty);

	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n)
			line_cnt_reg <= 20'h00000;
		else
			line_cnt_reg <= line_tick ? 20'h00000 : line_cnt_reg + 20'h00001;
	end

	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n)
			line_reg <= 5'h00;
		else if (line_tick)
			line_reg <= (line_reg + 5'h01) & line_mask(duty);
	end

	// panel line shows start plus offset, modulo duty
	assign display_on_y = (start_reg + line_reg) & line_mask(duty);

	////////////////////////////////////////////////////////////////////////////
	// Blink timer

	logic [6:0] blink_cnt_reg;
	logic       blink_off_reg;

	// equal shown and blanked halves on frame edges
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			blink_cnt_reg <= 7'h00;
			blink_off_reg <= 1'b0;
		end else if (!ctrl2_reg[`LCDC_C2_BLINK]) begin
			blink_cnt_reg <= 7'h00;
			blink_off_reg <= 1'b0;
		end else if (frame_tick) begin
			if (blink_cnt_reg == 7'(BLINK_HALF_FRAMES - 1)) begin
				blink_cnt_reg <= 7'h00;
				blink_off_reg <= !blink_off_reg;
			end else begin
				blink_cnt_reg <= blink_cnt_reg + 7'h01;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Segment and common drive

	logic [4:0]  y_d_reg;
	logic [4:0]  line_d_reg;
	logic [63:0] seg_next;
	logic        row_blinks;
	logic        blank;

	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			y_d_reg    <= 5'h00;
			line_d_reg <= 5'h00;
		end else begin
			y_d_reg    <= display_on_y;
			line_d_reg <= line_reg;
		end
	end

	// range compared with memory line, not panel line
	assign row_blinks = ctrl2_reg[`LCDC_C2_BLINK] && blink_off_reg &&
	                    y_d_reg >= blink_first_reg && y_d_reg <= blink_last_reg;

	// 5-bit groups in character mode, 8-bit in graphic
	// pattern bit per group, leftmost first
	always_comb begin
		logic [7:0] byte_v;
		logic [2:0] xmax;
		seg_next = 64'h0000000000000000;
		byte_v   = 8'h00;
		xmax     = x_limit(gfx, duty);
		for (int g = 0; g < 8; g++) begin
			byte_v = display_on_row[8*(7-g) +: 8];
			if (row_blinks && blink_pat_reg[7-g])
				byte_v = 8'h00;
			if (gfx) begin
				if (3'(g) <= xmax)
					seg_next[8*g +: 8] = {<<{byte_v}};
			end else begin
				seg_next[`LCDC_CHAR_BITS*g +: `LCDC_CHAR_BITS] = {<<{byte_v[4:0]}};
			end
		end
	end

	assign blank = standby || !ctrl2_reg[`LCDC_C2_DISPLAY_ON_ON];

	// standby or display off holds O_SEG and O_COM at ground
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			O_SEG <= 64'h0000000000000000;
			O_COM <= 32'h00000000;
		end else if (blank) begin
			O_SEG <= 64'h0000000000000000;
			O_COM <= 32'h00000000;
		end else begin
			O_SEG <= seg_next;
			O_COM <= 32'h00000001 << line_d_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Step-up and op-amp control

	logic pump_run;

	// standby request bit kills pump on the same edge as chip standby
	// chip standby stops the pump on the next edge
	// cleared step-up bit halts the pump
	assign pump_run = ctrl1_reg[`LCDC_C1_STEP_UP] && !standby && !I_CHIP_STANDBY;

	// pump clock is the gated subclock
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n) begin
			O_PUMP_EN  <= 1'b0;
			O_PUMP_CLK <= 1'b0;
		end else begin
			O_PUMP_EN  <= pump_run;
			O_PUMP_CLK <= pump_run && I_SUBCLK;
		end
	end

	// followers run only with the op-amp bit
	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n)
			O_OPAMP_EN <= 1'b0;
		else
			O_OPAMP_EN <= ctrl2_reg[`LCDC_C2_OPAMP] && !standby && !I_CHIP_STANDBY;
	end

	always_ff @(posedge I_CLK or negedge rst_n) begin
		if (!rst_n)
			O_CONTRAST <= 4'h0;
		else
			O_CONTRAST <= contrast_reg;
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_rmw_read_hold: assert property (@(posedge I_CLK) disable iff (!rst_n)
		data_rd && rmw && !reg_wr |=> ptr_reg == $past(ptr_reg))
		else $error("pointer moved on read-modify-write read");

	a_norm_read_step: assert property (@(posedge I_CLK) disable iff (!rst_n)
		data_rd && !rmw && !ctrl2_reg[`LCDC_C2_AXIS] && ptr_reg.y != `LCDC_Y_MAX
		|=> ptr_reg.y == $past(ptr_reg.y) + 5'h01 && ptr_reg.x == $past(ptr_reg.x))
		else $error("normal read did not step Y");

	a_axis_x_step: assert property (@(posedge I_CLK) disable iff (!rst_n)
		data_wr && ctrl2_reg[`LCDC_C2_AXIS] && ptr_reg.x < x_limit(gfx, duty)
		|=> ptr_reg.x == $past(ptr_reg.x) + 3'h1 && $stable(ptr_reg.y))
		else $error("X step wrong");

	a_y_wrap_carry: assert property (@(posedge I_CLK) disable iff (!rst_n)
		data_wr && !ctrl2_reg[`LCDC_C2_AXIS] && ptr_reg.y == `LCDC_Y_MAX &&
		ptr_reg.x == 3'h0 |=> ptr_reg.y == 5'h00 && ptr_reg.x == 3'h1)
		else $error("Y wrap did not carry into X");

	a_standby_ground: assert property (@(posedge I_CLK) disable iff (!rst_n)
		standby |=> O_SEG == 64'h0000000000000000 && O_COM == 32'h00000000)
		else $error("outputs driven in standby");

	a_standby_bits: assert property (@(posedge I_CLK) disable iff (!rst_n)
		standby |=> !ctrl2_reg[`LCDC_C2_DISPLAY_ON_ON] && !ctrl2_reg[`LCDC_C2_OPAMP])
		else $error("display or op-amp bit kept in standby");

	a_pump_chip_off: assert property (@(posedge I_CLK) disable iff (!rst_n)
		I_CHIP_STANDBY |-> ##[1:2] !O_PUMP_EN && !O_PUMP_CLK)
		else $error("pump still running in chip standby");

	a_amp_off: assert property (@(posedge I_CLK) disable iff (!rst_n)
		!ctrl2_reg[`LCDC_C2_OPAMP] && !ctrl1_reg[`LCDC_C1_STEP_UP]
		|=> !O_OPAMP_EN && !O_PUMP_EN)
		else $error("power circuits on with both bits clear");

	a_blink_frames: assert property (@(posedge I_CLK) disable iff (!rst_n)
		!frame_tick && ctrl2_reg[`LCDC_C2_BLINK] |=> $stable(blink_off_reg))
		else $error("blink phase changed between frames");

	a_read_only_data: assert property (@(posedge I_CLK) disable iff (!rst_n)
		bus.rd && !data_rd |=> O_RDATA == 8'h00)
		else $error("non-data register returned data");

endmodule

// [lcdc_cpu_model.sv]
// CPU-side master for the index and data registers
`timescale 1ns/100ps
module lcdc_cpu_model
	import lcdc_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic [7:0] i_rdata,
	output lcdc_bus_t       o_bus
);
	initial begin
		o_bus = '0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Strobe for one cycle, then idle one, so no strobe is driven twice per step
	task automatic xfer(input logic rs, input logic wr, input logic [7:0] d,
		output logic [7:0] q);
		o_bus <= '{rs: rs, wr: wr, rd: !wr, wdata: d};
		@(posedge i_clk);
		o_bus <= '0;
		@(negedge i_clk);
		q = i_rdata;
		@(posedge i_clk);
	endtask

	task automatic sel(input logic [3:0] idx);
		logic [7:0] q;
		xfer(1'b0, 1'b1, {4'h0, idx}, q);
	endtask

	task automatic wd(input logic [7:0] d);
		logic [7:0] q;
		xfer(1'b1, 1'b1, d, q);
	endtask

	task automatic rd(output logic [7:0] q);
		xfer(1'b1, 1'b0, 8'h00, q);
	endtask

	task automatic wreg(input logic [3:0] idx, input logic [7:0] d);
		sel(idx);
		wd(d);
	endtask
endmodule

// [lcdc_top_test.sv]
// Self-checking bench for the display controller top
`timescale 1ns/100ps
module lcdc_top_test
	import lcdc_pkg::*;
;
	localparam int LC = 4;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        chip_sb = 1'b0;
	logic [3:0]  sub_cnt = 4'h0;
	lcdc_bus_t   bus;
	logic [7:0]  rdata;
	logic [31:0] com;
	logic [63:0] seg;
	logic        pump_en;
	logic        pump_clk;
	logic        opamp_en;
	logic [3:0]  contrast;
	int          mismatches = 0;
	int          n_checks = 0;
	logic [7:0]  q;
	logic [7:0]  d0;
	logic [31:0] r;
	logic        s;
	int          vis;
	int          blank;
	// Row: ctrl1, ctrl2, pointer, pointer expected one step later
	logic [31:0] rows [11] = '{32'h0000_0001, 32'h0000_1f20, 32'h0008_4363,
		32'h0008_e506, 32'h0008_ff00, 32'h0408_8203, 32'h0508_c90a,
		32'h0608_e203, 32'h0400_9f00, 32'h0010_2728, 32'h0018_e405};

	always #10 clk = ~clk;
	always @(posedge clk) sub_cnt <= sub_cnt + 4'h1;

	lcdc_top #(.LINE_CYCLES(LC)) DUT (
		.I_CLK(clk), .I_RST_N(rst_n), .I_RS(bus.rs), .I_WR(bus.wr),
		.I_RD(bus.rd), .I_WDATA(bus.wdata), .O_RDATA(rdata),
		.I_CHIP_STANDBY(chip_sb), .I_SUBCLK(sub_cnt[3]), .O_COM(com),
		.O_SEG(seg), .O_PUMP_EN(pump_en), .O_PUMP_CLK(pump_clk),
		.O_OPAMP_EN(opamp_en), .O_CONTRAST(contrast));

	lcdc_cpu_model cpu (.i_clk(clk), .i_rdata(rdata), .o_bus(bus));

	////////////////////////////////////////////////////////////////////////////
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk64(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic at(input logic [7:0] p);
		cpu.wreg(4'h2, p);
		cpu.sel(4'h4);
	endtask

	// Leave the current line first, so each call sees a fresh frame
	task automatic line15();
		int i;
		for (i = 0; i < 20 && com === 32'h8000; i++) @(negedge clk);
		for (i = 0; i < 400 && com !== 32'h8000; i++) @(negedge clk);
		chk64({32'h0, com}, 64'h8000);
	endtask

	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk64(seg | {32'h0, com}, 64'h0);
		chk8(rdata | {6'h0, pump_en, opamp_en}, 8'h00);
		@(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 11; i++) begin
			r = rows[i];
			d0 = 8'h3c + 8'(i);
			cpu.wreg(4'h0, r[31:24]);
			cpu.wreg(4'h1, r[23:16]);
			at(r[15:8]);
			cpu.wd(d0);
			cpu.wd(~d0);
			at(r[15:8]);
			cpu.rd(q);
			chk8(q, d0);
			cpu.rd(q);
			chk8(q, r[20] ? d0 : ~d0);
			at(r[7:0]);
			cpu.rd(q);
			chk8(q, ~d0);
		end
		cpu.wreg(4'h0, 8'h01);
		cpu.wreg(4'h1, 8'h08);
		at(8'h00);
		for (int i = 0; i < 8; i++) cpu.wd(i < 2 ? 8'h90 : 8'h00);
		cpu.wreg(4'h3, 8'h01);
		cpu.wreg(4'h6, 8'h80);
		cpu.wreg(4'h8, 8'h00);
		cpu.wreg(4'h9, 8'h00);
		cpu.wreg(4'h1, 8'h09);
		line15();
		chk64(seg, 64'h21);
		cpu.wreg(4'h0, 8'h05);
		line15();
		chk64(seg, 64'h909);
		cpu.wreg(4'h1, 8'h0d);
		vis = 0;
		blank = 0;
		for (int f = 0; f < 200 && !(blank > 0 && vis > 0); f++) begin
			line15();
			if (seg === 64'h900)
				blank++;
			else if (blank > 0)
				vis++;
		end
		chk8(8'(blank), 8'h40);
		chk64(seg, 64'h909);
		@(posedge clk);
		cpu.wreg(4'h1, 8'h0b);
		cpu.wreg(4'h0, 8'h0d);
		@(negedge clk);
		chk8({6'h0, pump_en, opamp_en}, 8'h03);
		s = sub_cnt[3];
		@(negedge clk);
		chk8({7'h0, pump_clk}, {7'h0, s});
		repeat (8) @(negedge clk);
		chk8({7'h0, pump_clk}, {7'h0, !s});
		@(posedge clk);
		chip_sb <= 1'b1;
		repeat (2) @(negedge clk);
		chk8({7'h0, pump_en}, 8'h00);
		@(posedge clk);
		chip_sb <= 1'b0;
		cpu.wreg(4'h0, 8'h1d);
		@(negedge clk);
		chk64(seg | {32'h0, com}, 64'h0);
		chk8({6'h0, pump_en, opamp_en}, 8'h00);
		@(posedge clk);
		cpu.wreg(4'ha, 8'h09);
		@(negedge clk);
		chk8({4'h0, contrast}, 8'h09);
		@(posedge clk);
		cpu.wreg(4'h0, 8'h0d);
		repeat (200) @(negedge clk);
		chk64({32'h0, com}, 64'h0);
		chk8({6'h0, pump_en, opamp_en}, 8'h02);
		@(posedge clk);
		at(8'h00);
		cpu.rd(q);
		chk8(q, 8'h90);
		cpu.sel(4'ha);
		cpu.rd(q);
		chk8(q, 8'h00);
		cpu.wreg(4'h0, 8'h05);
		@(negedge clk);
		chk8({6'h0, pump_en, opamp_en}, 8'h00);
		end_of_test();
	end

	// Blink run dominates; about 20k cycles expected
	initial begin
		#800000;
		mismatches++;
		end_of_test();
	end
endmodule
